// ### src/lpbst_ctrl.sv
// lpddr2 command controller: terminate, mask, precharge and auto-precharge
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module lpbst_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic ck_t,
   output logic ck_c,
   output logic cke,
   output logic cs_n,
   output logic [9:0] ca,
   output logic [15:0] dq_out,
   input wire logic [15:0] dq_in,
   output logic dq_oe_n,
   output logic dqs_out,
   output logic dqs_oe_n,
   output logic [1:0] dm
);
   localparam int NB = 4;
   localparam int CW = lpbst_pkg::CW;

   logic [1:0] phase_r;
   lpbst_pkg::lpbst_st_t st_r;
   logic [1:0] cfg_bl_r;
   logic [15:0] wdata_r;
   logic [1:0] wmask_r;
   logic pend_r;
   logic [15:0] pcmd_r;
   logic refused_r;
   logic [31:0] rdata_r;
   logic [9:0] ca_r;
   logic [9:0] ca_fall_r;
   logic cs_n_r;
   logic ck_r;
   logic cke_r;
   logic [15:0] dq_s1_r;
   logic [15:0] dq_s2_r;
   logic [15:0] rd_word_r;
   logic seen_r;
   logic last_wr_r;
   logic last_ap_r;
   logic bst_done_r;
   logic [1:0] last_bank_r;
   logic [CW-1:0] since_r;
   logic [CW-1:0] eff_half_r;
   logic [CW-1:0] wr_cnt_r;
   logic [CW-1:0] wr_len_r;
   logic [CW-1:0] rd_cnt_r;
   logic dq_oe_n_r;
   logic dqs_r;
   logic [15:0] dq_out_r;
   logic [1:0] dm_r;
   logic [NB-1:0] b_open;
   logic [NB-1:0] b_pre_ok;
   logic [NB-1:0] b_act_ok;
   logic [NB-1:0] b_ap;

   // register port decode
   wire wr_cmd = reg_wr && (reg_addr == lpbst_pkg::ADDR_CMD);
   wire wr_cfg = reg_wr && (reg_addr == lpbst_pkg::ADDR_CFG);
   wire wr_wdat = reg_wr && (reg_addr == lpbst_pkg::ADDR_WDATA);
   wire rd_stat = reg_rd && (reg_addr == lpbst_pkg::ADDR_STATUS);
   wire busy = pend_r || (st_r != lpbst_pkg::ST_IDLE);
   wire [31:0] stat_word = {rd_word_r, 10'h000, b_open, refused_r, busy};
   wire [31:0] rd_sel =
      (reg_addr == lpbst_pkg::ADDR_CFG) ? {30'h00000000, cfg_bl_r} :
      (reg_addr == lpbst_pkg::ADDR_WDATA) ? {14'h0000, wmask_r, wdata_r} :
      (reg_addr == lpbst_pkg::ADDR_STATUS) ? stat_word : 32'h00000000;

   // link clock: ck high in phases 1 and 2, so ca changes a full clk from each edge
   wire tick = (phase_r == 2'h1);
   wire issue_slot = (st_r == lpbst_pkg::ST_IDLE) && pend_r && (phase_r == 2'h3);

   // pending command fields
   wire [2:0] op = pcmd_r[lpbst_pkg::CMD_OP_LSB +: 3];
   wire [1:0] bank = pcmd_r[lpbst_pkg::CMD_BANK_LSB +: 2];
   wire ap = pcmd_r[lpbst_pkg::CMD_AP_BIT];
   wire [9:0] adr = pcmd_r[lpbst_pkg::CMD_ADDR_LSB +: 10];
   wire is_act = (op == lpbst_pkg::OP_ACT);
   wire is_rd = (op == lpbst_pkg::OP_RD);
   wire is_wr = (op == lpbst_pkg::OP_WR);
   wire is_bst = (op == lpbst_pkg::OP_BST);
   wire is_pre = (op == lpbst_pkg::OP_PRE);
   wire is_prea = (op == lpbst_pkg::OP_PREA);

   // programmed burst length as link cycles
   wire [CW-1:0] bl_half =
      (cfg_bl_r == lpbst_pkg::BL_CODE4) ? CW'(2) :
      (cfg_bl_r == lpbst_pkg::BL_CODE8) ? CW'(4) : CW'(8);

   // legality of each command
   wire [CW-1:0] turn_ex = (is_wr && seen_r && !last_wr_r) ? CW'(lpbst_pkg::RD2WR_EX) :
      (is_rd && seen_r && last_wr_r) ? CW'(lpbst_pkg::WR2RD_EX) : CW'(0);
   wire rw_gap_ok = !seen_r || (since_r >= eff_half_r + turn_ex);
   wire rw_ok = (is_rd || is_wr) && b_open[bank] && !b_ap[bank] && rw_gap_ok;
   wire bst_ok = is_bst && seen_r && !bst_done_r && !last_ap_r
      && (since_r <= bl_half - 1'b1)
      && (since_r != '0) && !since_r[0];
   wire act_ok = is_act && b_act_ok[bank];
   wire pre_ok = is_pre && b_pre_ok[bank];
   wire prea_ok = is_prea && (&b_pre_ok);
   wire legal = rw_ok || bst_ok || act_ok || pre_ok || prea_ok;
   wire fire = issue_slot && legal;

   // command words, rising half then falling half
   wire [9:0] ca_rise =
      is_act ? {1'b0, bank, adr[4:0], 2'b10} :
      (is_rd || is_wr) ? {1'b0, bank, adr[1:0], 2'b00, is_rd, 2'b01} :
      is_bst ? 10'h003 :
      is_pre ? {1'b0, bank, 2'b00, 1'b0, 4'hB} :
      {5'h00, 1'b1, 4'hB};
   wire [9:0] ca_fall = (is_rd || is_wr) ? {adr[9:1], ap} :
      is_act ? adr : 10'h000;

   // per-bank recovery loads
   wire [CW-1:0] rd_pre_v = bl_half + CW'(lpbst_pkg::RTP_EX);
   wire [CW-1:0] wr_pre_v = bl_half + CW'(lpbst_pkg::WL + lpbst_pkg::WR_CK + 1);
   wire [CW-1:0] bst_pre_v = last_wr_r ? CW'(lpbst_pkg::BST_WR_PRE) :
      CW'(lpbst_pkg::BST_RD_PRE);
   wire wr_win = (wr_cnt_r != '0) && (wr_cnt_r <= wr_len_r);
   // keep driving until the last strobe pulse has fallen, or the final beat is lost
   wire wr_drive = wr_win || dqs_r;

   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++) begin : g_bank
         wire hit = (bank == 2'(gb));
         lpbst_bank #(.CW(CW)) u_bank (
            .clk(clk),
            .resetn(resetn),
            .tick(tick),
            .do_act(fire && is_act && hit),
            .do_rd(fire && is_rd && hit),
            .do_wr(fire && is_wr && hit),
            .do_pre(fire && (is_prea || (is_pre && hit))),
            .do_bst(fire && is_bst && (last_bank_r == 2'(gb))),
            .ap(ap),
            .rd_pre(rd_pre_v),
            .wr_pre(wr_pre_v),
            .bst_pre(bst_pre_v),
            .is_open(b_open[gb]),
            .pre_ok(b_pre_ok[gb]),
            .act_ok(b_act_ok[gb]),
            .ap_busy(b_ap[gb])
         );
      end
   endgenerate

   // software registers; a refusal in the same cycle as a status read stays set
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_bl_r <= lpbst_pkg::CFG_RST;
         wdata_r <= 16'h0000;
         wmask_r <= 2'h0;
         refused_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         if (wr_cfg && reg_wdata[1:0] != 2'h3) begin
            cfg_bl_r <= reg_wdata[1:0];
         end
         if (wr_wdat) begin
            wdata_r <= reg_wdata[15:0];
            wmask_r <= reg_wdata[17:16];
         end
         if ((issue_slot && !legal) || (wr_cmd && busy)) begin
            refused_r <= 1'b1;
         end else if (rd_stat) begin
            refused_r <= 1'b0;
         end
         rdata_r <= reg_rd ? rd_sel : 32'h00000000;
      end
   end

   // one command is held until its slot; a write while busy is dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_r <= 1'b0;
         pcmd_r <= 16'h0000;
      end else if (wr_cmd && !busy) begin
         pend_r <= 1'b1;
         pcmd_r <= reg_wdata[15:0];
      end else if (issue_slot) begin
         pend_r <= 1'b0;
      end
   end

   // link clock divider and command sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase_r <= 2'h0;
         ck_r <= 1'b0;
         cke_r <= 1'b0;
         st_r <= lpbst_pkg::ST_IDLE;
         cs_n_r <= 1'b1;
         ca_r <= 10'h000;
         ca_fall_r <= 10'h000;
      end else begin
         phase_r <= phase_r + 2'h1;
         ck_r <= (phase_r == 2'h0) || (phase_r == 2'h1);
         cke_r <= 1'b1;
         case (st_r)
            lpbst_pkg::ST_IDLE: begin
               if (fire) begin
                  cs_n_r <= 1'b0;
                  ca_r <= ca_rise;
                  ca_fall_r <= ca_fall;
                  st_r <= lpbst_pkg::ST_RISE;
               end
            end
            lpbst_pkg::ST_RISE: begin
               if (phase_r == 2'h1) begin
                  ca_r <= ca_fall_r;
                  st_r <= lpbst_pkg::ST_FALL;
               end
            end
            lpbst_pkg::ST_FALL: begin
               if (phase_r == 2'h3) begin
                  cs_n_r <= 1'b1;
                  ca_r <= 10'h000;
                  st_r <= lpbst_pkg::ST_IDLE;
               end
            end
            default: st_r <= lpbst_pkg::ST_IDLE;
         endcase
      end
   end

   // newest burst record: terminate acts only on this one
   always_ff @(posedge clk) begin
      if (!resetn) begin
         seen_r <= 1'b0;
         last_wr_r <= 1'b0;
         last_ap_r <= 1'b0;
         bst_done_r <= 1'b0;
         last_bank_r <= 2'h0;
         since_r <= '0;
         eff_half_r <= '0;
      end else if (fire && (is_rd || is_wr)) begin
         seen_r <= 1'b1;
         last_wr_r <= is_wr;
         last_ap_r <= ap;
         bst_done_r <= 1'b0;
         last_bank_r <= bank;
         since_r <= '0;
         eff_half_r <= bl_half;
      end else if (fire && is_bst) begin
         bst_done_r <= 1'b1;
         eff_half_r <= since_r;
      end else if (tick && since_r != {CW{1'b1}}) begin
         since_r <= since_r + 1'b1;
      end
   end

   // write data window: starts WL after the write, ends WL after a terminate
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_cnt_r <= '0;
         wr_len_r <= '0;
      end else if (fire && is_wr) begin
         wr_cnt_r <= bl_half + CW'(lpbst_pkg::WL);
         wr_len_r <= bl_half;
      end else if (fire && is_bst && last_wr_r && wr_cnt_r > CW'(lpbst_pkg::WL)) begin
         wr_cnt_r <= CW'(lpbst_pkg::WL);
      end else if (tick && wr_cnt_r != '0) begin
         wr_cnt_r <= wr_cnt_r - 1'b1;
      end
   end

   // read capture: last beat is sampled; terminated reads capture earlier
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_cnt_r <= '0;
         rd_word_r <= 16'h0000;
      end else if (fire && is_rd) begin
         rd_cnt_r <= bl_half + CW'(lpbst_pkg::RD_CAP);
      end else if (fire && is_bst && !last_wr_r) begin
         rd_cnt_r <= CW'(lpbst_pkg::RD_CAP);
      end else if (tick && rd_cnt_r != '0) begin
         rd_cnt_r <= rd_cnt_r - 1'b1;
         if (rd_cnt_r == CW'(1)) begin
            rd_word_r <= dq_s2_r;
         end
      end
   end

   // pin path; dq input passes two flops since it comes from the device
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dq_s1_r <= 16'h0000;
         dq_s2_r <= 16'h0000;
         dq_oe_n_r <= 1'b1;
         dqs_r <= 1'b0;
         dq_out_r <= 16'h0000;
         dm_r <= 2'h0;
      end else begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
         dq_oe_n_r <= !wr_drive;
         // strobe lags ck by a quarter period; a pulse once begun runs its half cycle
         dqs_r <= (phase_r == 2'h1) ? wr_win : ((phase_r == 2'h2) && dqs_r);
         dq_out_r <= wdata_r;
         dm_r <= wr_drive ? wmask_r : 2'h0;
      end
   end

   assign reg_rdata = rdata_r;
   assign ck_t = ck_r;
   assign ck_c = !ck_r;
   assign cke = cke_r;
   assign cs_n = cs_n_r;
   assign ca = ca_r;
   assign dq_out = dq_out_r;
   assign dq_oe_n = dq_oe_n_r;
   assign dqs_out = dqs_r;
   assign dqs_oe_n = dq_oe_n_r;
   assign dm = dm_r;
endmodule

// ### src/lpbst_pkg.sv
// constants, register map and types of the lpddr2 command controller
package lpbst_pkg;
   // clock and link timing, times in picoseconds
   localparam int CLK_PS = 40000;
   localparam int CK_DIV = 4;
   localparam int TCK_PS = CLK_PS * CK_DIV;
   localparam int T_WR_PS = 15000;
   localparam int T_RTP_PS = 7500;
   localparam int T_WTR_PS = 7500;
   localparam int T_RP_PS = 18000;
   localparam int T_RAS_PS = 42000;
   localparam int T_RC_PS = 60000;
   localparam int T_DQSCK_PS = 5500;
   // least times round up to whole link clock cycles
   localparam int WR_CK = (T_WR_PS + TCK_PS - 1) / TCK_PS;
   localparam int RTP_CK = (T_RTP_PS + TCK_PS - 1) / TCK_PS;
   localparam int WTR_CK = (T_WTR_PS + TCK_PS - 1) / TCK_PS;
   localparam int RP_CK = (T_RP_PS + TCK_PS - 1) / TCK_PS;
   localparam int RAS_CK = (T_RAS_PS + TCK_PS - 1) / TCK_PS;
   localparam int RC_CK = (T_RC_PS + TCK_PS - 1) / TCK_PS;
   localparam int DQSCK_CK = (T_DQSCK_PS + TCK_PS - 1) / TCK_PS;
   localparam int RL = 3;
   localparam int WL = 1;
   localparam int RTP_EX = ((RTP_CK > 2) ? RTP_CK : 2) - 2;
   localparam int BST_RD_PRE = (RTP_EX > 1) ? RTP_EX : 1;
   localparam int BST_WR_PRE = WL + WR_CK + 1;
   localparam int RD2WR_EX = RL + DQSCK_CK + 1 - WL;
   localparam int WR2RD_EX = WL + 1 + WTR_CK;
   localparam int RD_CAP = RL + DQSCK_CK + 1;
   // per-bank counter width
   localparam int CW = 8;
   // software register offsets and reset values
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_WDATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [1:0] CFG_RST = 2'h1;
   localparam logic [1:0] BL_CODE4 = 2'h0;
   localparam logic [1:0] BL_CODE8 = 2'h1;
   // command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BANK_LSB = 3;
   localparam int CMD_AP_BIT = 5;
   localparam int CMD_ADDR_LSB = 6;
   localparam logic [2:0] OP_ACT = 3'h0;
   localparam logic [2:0] OP_RD = 3'h1;
   localparam logic [2:0] OP_WR = 3'h2;
   localparam logic [2:0] OP_BST = 3'h3;
   localparam logic [2:0] OP_PRE = 3'h4;
   localparam logic [2:0] OP_PREA = 3'h5;
   // status fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_REF_BIT = 1;
   localparam int ST_OPEN_LSB = 2;
   localparam int ST_RDATA_LSB = 16;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RISE = 3'b010,
      ST_FALL = 3'b100
   } lpbst_st_t;
endpackage

// ### src/lpbst_bank.sv
// per-bank open state and precharge / activate interval counters
`timescale 1ns/1ps
module lpbst_bank #(
   parameter int CW = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic do_act,
   input wire logic do_rd,
   input wire logic do_wr,
   input wire logic do_pre,
   input wire logic do_bst,
   input wire logic ap,
   input wire logic [CW-1:0] rd_pre,
   input wire logic [CW-1:0] wr_pre,
   input wire logic [CW-1:0] bst_pre,
   output logic is_open,
   output logic pre_ok,
   output logic act_ok,
   output logic ap_busy
);
   localparam logic [CW-1:0] RAS_V = CW'(lpbst_pkg::RAS_CK);
   localparam logic [CW-1:0] RC_V = CW'(lpbst_pkg::RC_CK);
   localparam logic [CW-1:0] RP_V = CW'(lpbst_pkg::RP_CK);
   logic open_r;
   logic ap_r;
   logic [CW-1:0] pre_cnt_r;
   logic [CW-1:0] act_cnt_r;
   wire ap_close = ap_r && (pre_cnt_r == '0);
   wire [CW-1:0] rw_load = do_rd ? rd_pre : wr_pre;
   wire [CW-1:0] rw_max = (rw_load > pre_cnt_r) ? rw_load : pre_cnt_r;
   wire [CW-1:0] rp_max = (RP_V > act_cnt_r) ? RP_V : act_cnt_r;

   // earliest precharge: tRAS after activate, read/write recovery after access
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pre_cnt_r <= '0;
      end else if (do_act) begin
         pre_cnt_r <= RAS_V;
      end else if (do_rd || do_wr) begin
         pre_cnt_r <= rw_max;
      end else if (do_bst) begin
         pre_cnt_r <= bst_pre;
      end else if (tick && pre_cnt_r != '0) begin
         pre_cnt_r <= pre_cnt_r - 1'b1;
      end
   end

   // earliest activate: tRC after activate, tRP after any precharge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         act_cnt_r <= '0;
      end else if (do_act) begin
         act_cnt_r <= RC_V;
      end else if (do_pre || ap_close) begin
         act_cnt_r <= rp_max;
      end else if (tick && act_cnt_r != '0) begin
         act_cnt_r <= act_cnt_r - 1'b1;
      end
   end

   // the device closes the bank itself when the auto-precharge point is reached
   always_ff @(posedge clk) begin
      if (!resetn) begin
         open_r <= 1'b0;
         ap_r <= 1'b0;
      end else if (do_act) begin
         open_r <= 1'b1;
         ap_r <= 1'b0;
      end else if (do_pre || ap_close) begin
         open_r <= 1'b0;
         ap_r <= 1'b0;
      end else if ((do_rd || do_wr) && ap) begin
         ap_r <= 1'b1;
      end
   end

   assign is_open = open_r;
   assign ap_busy = ap_r;
   assign pre_ok = !ap_r && (!open_r || pre_cnt_r == '0);
   assign act_ok = !open_r && !ap_r && (act_cnt_r == '0);
endmodule

// ### sim/lpbst_ctrl_asserts.sv
// port-level protocol checker for the lpddr2 command controller
`timescale 1ns/1ps
module lpbst_ctrl_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic ck_t,
   input wire logic ck_c,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic [9:0] ca,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_in,
   input wire logic dq_oe_n,
   input wire logic dqs_out,
   input wire logic dqs_oe_n,
   input wire logic [1:0] dm
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_RDATA_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   AST_CK_SHAPE: assert property ($rose(ck_t) |=> ck_t ##1 !ck_t ##1 !ck_t ##1 ck_t && !ck_c)
      else $error("link clock not two high two low");
   AST_CS_WIDTH: assert property ($fell(cs_n) |-> !cs_n [*4] ##1 cs_n)
      else $error("chip select not one link cycle");
   AST_CS_PHASE: assert property ($fell(cs_n) |-> !ck_t ##1 ck_t)
      else $error("command word not set up before clock rise");
   AST_CMD_GAP: assert property ($fell(cs_n) |=> (!$fell(cs_n)) [*7])
      else $error("commands closer than two link cycles");
   AST_BST_WORD: assert property ($rose(ck_t) && !cs_n && ca[3:0] == 4'h3 |-> ca[9:4] == 6'h00)
      else $error("terminate rising word wrong");
   AST_RD_PRE: assert property ($rose(ck_t) && !cs_n && ca[2:0] == 3'b101
      |=> (cs_n || ca[3:0] != 4'hB) [*7])
      else $error("precharge too soon after read");
   AST_MASK_IDLE: assert property (dq_oe_n |-> dm == 2'h0)
      else $error("mask driven outside write window");
   AST_STROBE_OE: assert property (dqs_oe_n == dq_oe_n && (!dq_oe_n || !dqs_out))
      else $error("strobe and data enables differ");
   AST_WR_WINDOW: assert property ($rose(ck_t) && !cs_n && ca[2:0] == 3'b001
      |-> ##[2:12] !dq_oe_n)
      else $error("write data window missing");
   AST_CKE_UP: assert property ($past(resetn) |-> cke)
      else $error("clock enable low after reset");
endmodule
bind lpbst_ctrl lpbst_ctrl_chk lpbst_ctrl_chk_i (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .ck_t, .ck_c, .cke, .cs_n, .ca, .dq_out, .dq_in, .dq_oe_n, .dqs_out,
   .dqs_oe_n, .dm);

// ### sim/lpbst_dev_model.sv
// behavioural lpddr2 device seen across the controller's link pins
`timescale 1ns/1ps
module lpbst_dev_model (
   input wire logic ck_t,
   input wire logic cs_n,
   input wire logic [9:0] ca,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic dqs_out,
   input wire logic [1:0] dm,
   input wire logic [4:0] bl,
   output logic [15:0] dq_in,
   output logic [3:0] open_banks,
   output logic [4:0] eff_len,
   output int beats
);
   logic [15:0] mem [4] = '{default: 16'h0000};
   logic [9:0] rise_w = 10'h000;
   logic cmd_v = 1'b0;
   logic rd_on = 1'b0;
   logic [1:0] bank = 2'h0;
   int age = 99;
   int ap_cnt = 0;
   initial begin
      dq_in = 16'h0000;
      open_banks = 4'h0;
      eff_len = 5'h00;
      beats = 0;
   end
   always @(posedge ck_t) begin
      cmd_v <= !cs_n;
      rise_w <= ca;
      age <= age + 1;
      // no pull on dq: flip every link cycle so stale data never passes for a read
      if (rd_on && age >= 2 && age <= lpbst_pkg::RL + 2 + eff_len / 2) begin
         dq_in <= mem[bank];
      end else begin
         dq_in <= ~dq_in;
      end
      if (ap_cnt == 1) begin
         open_banks[bank] <= 1'b0;
      end
      if (ap_cnt > 0) begin
         ap_cnt <= ap_cnt - 1;
      end
   end
   always @(negedge ck_t) begin
      if (cmd_v) begin
         if (rise_w[1:0] == 2'b10) begin
            open_banks[rise_w[8:7]] <= 1'b1;
         end else if (rise_w[1:0] == 2'b01) begin
            bank <= rise_w[8:7];
            rd_on <= rise_w[2];
            age <= 0;
            beats <= 0;
            eff_len <= bl;
            ap_cnt <= ca[0] ? int'(bl) / 2 + 2 : 0;
         end else if (rise_w[3:0] == 4'h3) begin
            eff_len <= 5'(2 * age);
         end else if (rise_w[3:0] == 4'hB) begin
            if (rise_w[4]) begin
               open_banks <= 4'h0;
            end else begin
               open_banks[rise_w[8:7]] <= 1'b0;
            end
         end
      end
   end
   // look a step after the strobe edge, once mask, enable and bank have settled
   always @(dqs_out) begin
      #1;
      if (!dq_oe_n) begin
         beats = beats + 1;
         for (int b = 0; b < 2; b++) begin
            if (!dm[b]) begin
               mem[bank][b*8 +: 8] = dq_out[b*8 +: 8];
            end
         end
      end
   end
endmodule

// ### sim/lpbst_ctrl_tb.sv
// self-checking bench for the lpddr2 command controller
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module lpbst_ctrl_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic ck_t, ck_c, cke, cs_n, dq_oe_n, dqs_out, dqs_oe_n;
   logic [9:0] ca;
   logic [15:0] dq_out, dq_in;
   logic [1:0] dm;
   logic [4:0] bl = 5'h08;
   logic [3:0] dev_open;
   logic [4:0] dev_eff;
   int dev_beats;
   logic [31:0] d;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   lpbst_ctrl lpbst_ctrl_i (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ck_t, .ck_c, .cke, .cs_n, .ca, .dq_out, .dq_in, .dq_oe_n, .dqs_out, .dqs_oe_n, .dm);
   lpbst_dev_model lpbst_dev_model_i (.ck_t, .cs_n, .ca, .dq_out, .dq_oe_n, .dqs_out, .dm, .bl,
      .dq_in, .open_banks(dev_open), .eff_len(dev_eff), .beats(dev_beats));
   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   function automatic logic [31:0] cmdw(input logic [2:0] op, input logic [1:0] bk,
      input logic ap);
      cmdw = 32'h0;
      cmdw[lpbst_pkg::CMD_OP_LSB +: 3] = op;
      cmdw[lpbst_pkg::CMD_BANK_LSB +: 2] = bk;
      cmdw[lpbst_pkg::CMD_AP_BIT] = ap;
   endfunction
   // fixed settle time covers the longest recovery plus tRP at BL16
   task automatic cmd(input logic [2:0] op, input logic [1:0] bk, input logic ap);
      wr(lpbst_pkg::ADDR_CMD, cmdw(op, bk, ap));
      repeat (64) @(posedge clk);
   endtask
   task automatic stat(input logic [3:0] open_e, input logic ref_e, input string what);
      logic [31:0] s;
      rd(lpbst_pkg::ADDR_STATUS, s);
      `CHK(what, open_e, s[lpbst_pkg::ST_OPEN_LSB +: 4])
      `CHK(what, ref_e, s[lpbst_pkg::ST_REF_BIT])
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(lpbst_pkg::ADDR_CFG, d);
      `CHK("cfg reset", 32'(lpbst_pkg::CFG_RST), d)
      rd(lpbst_pkg::ADDR_WDATA, d);
      `CHK("wdata reset", 32'h0, d)
      rd(lpbst_pkg::ADDR_CMD, d);
      `CHK("cmd read", 32'h0, d)
      rd(8'h10, d);
      `CHK("unmapped read", 32'h0, d)
      stat(4'h0, 1'b0, "status reset");
      for (int c = 0; c < 4; c++) begin
         wr(lpbst_pkg::ADDR_CFG, 32'(c));
         rd(lpbst_pkg::ADDR_CFG, d);
         `CHK("burst code", (c == 3) ? 32'h2 : 32'(c), d)
      end
      wr(lpbst_pkg::ADDR_CFG, 32'h1);
      for (int b = 0; b < 4; b++) begin
         cmd(lpbst_pkg::OP_ACT, 2'(b), 1'b0);
      end
      stat(4'hF, 1'b0, "all open");
      `CHK("device open", 4'hF, dev_open)
      cmd(lpbst_pkg::OP_ACT, 2'h1, 1'b0);
      stat(4'hF, 1'b1, "activate open bank");
      wr(lpbst_pkg::ADDR_WDATA, 32'h0002A55A);
      cmd(lpbst_pkg::OP_WR, 2'h0, 1'b0);
      cmd(lpbst_pkg::OP_RD, 2'h0, 1'b0);
      rd(lpbst_pkg::ADDR_STATUS, d);
      `CHK("masked read", 16'h005A, d[31:16])
      `CHK("open after plain burst", 4'hF, d[5:2])
      // both strobes land the same clocks after a link rise: two link cycles apart
      @(posedge ck_t);
      wr(lpbst_pkg::ADDR_CMD, cmdw(lpbst_pkg::OP_RD, 2'h1, 1'b0));
      repeat (2) @(posedge ck_t);
      wr(lpbst_pkg::ADDR_CMD, cmdw(lpbst_pkg::OP_BST, 2'h1, 1'b0));
      repeat (64) @(posedge clk);
      stat(4'hF, 1'b0, "terminate taken");
      `CHK("effective length", 5'h04, dev_eff)
      cmd(lpbst_pkg::OP_BST, 2'h1, 1'b0);
      stat(4'hF, 1'b1, "second terminate");
      cmd(lpbst_pkg::OP_PRE, 2'h2, 1'b0);
      stat(4'hB, 1'b0, "single bank close");
      cmd(lpbst_pkg::OP_PREA, 2'h0, 1'b0);
      stat(4'h0, 1'b0, "all bank close");
      `CHK("device closed", 4'h0, dev_open)
      cmd(lpbst_pkg::OP_RD, 2'h3, 1'b0);
      stat(4'h0, 1'b1, "read closed bank");
      cmd(lpbst_pkg::OP_ACT, 2'h3, 1'b0);
      cmd(lpbst_pkg::OP_RD, 2'h3, 1'b1);
      stat(4'h0, 1'b0, "read auto close");
      wr(lpbst_pkg::ADDR_CFG, 32'h2);
      bl <= 5'h10;
      cmd(lpbst_pkg::OP_ACT, 2'h0, 1'b0);
      cmd(lpbst_pkg::OP_WR, 2'h0, 1'b1);
      stat(4'h0, 1'b0, "write auto close");
      `CHK("device auto close", 4'h0, dev_open)
      `CHK("write beats", 16, dev_beats)
      cmd(lpbst_pkg::OP_ACT, 2'h2, 1'b0);
      @(posedge ck_t);
      wr(lpbst_pkg::ADDR_CMD, cmdw(lpbst_pkg::OP_WR, 2'h2, 1'b0));
      repeat (2) @(posedge ck_t);
      wr(lpbst_pkg::ADDR_CMD, cmdw(lpbst_pkg::OP_BST, 2'h2, 1'b0));
      repeat (64) @(posedge clk);
      stat(4'h4, 1'b0, "write terminate taken");
      `CHK("truncated write beats", 4, dev_beats)
      tally_and_finish();
   end
endmodule
